// *** core/amal_pkg.sv ***
// Package of constants, types and attribute functions for the bus master attribute logic
package amal_pkg;

  // Access sizes at the core request port
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // Bus transfer types
  localparam logic [1:0] TRANS_IDLE = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;

  // Protection attribute bit positions and values
  localparam int PROT_DATA_BIT = 0;
  localparam int PROT_PRIV_BIT = 1;
  localparam logic [3:0] PROT_CB_DATA = 4'hd;
  localparam logic [3:0] PROT_CB_OPCODE = 4'hc;
  localparam logic [3:0] PROT_B_DATA = 4'h5;
  localparam logic [3:0] PROT_B_OPCODE = 4'h4;
  localparam logic [3:0] PROT_NONCACHED_UNBUFFERED_DATA = 4'h1;
  localparam logic [3:0] PROT_NONCACHED_UNBUFFERED_OPCODE = 4'h0;
  localparam logic [3:0] PROT_WALK_DATA = 4'hf;
  localparam logic [3:0] PROT_WALK_INSTR = 4'he;
  localparam logic [3:0] PROT_WRITEBACK = 4'hf;

  // Byte lane patterns, little-endian numbering
  localparam logic [3:0] LANE_B0 = 4'h1;
  localparam logic [3:0] LANE_LOW_HALF = 4'h3;
  localparam logic [3:0] LANE_HIGH_HALF = 4'hc;
  localparam logic [3:0] LANE_ALL = 4'hf;
  localparam logic [1:0] ADDR_LOW_ZERO = 2'h0;

  typedef enum logic [1:0] {IK_LINEFILL, IK_NONCACHED_UNBUFFERED, IK_NCB} amal_ikind_type;
  typedef enum logic [2:0] {
    DK_LINEFILL, DK_NONCACHED_UNBUFFERED, DK_NCB, DK_WTWB, DK_WRITEBACK, DK_WALK_DATA, DK_WALK_INSTR, DK_SWAP
  } amal_dkind_type;
  typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_ADDR, ST_DATA} amal_state_type;

  function automatic logic [3:0] amal_iprot(input amal_ikind_type kind, input logic priv);
    logic [3:0] p;
    case (kind)
      IK_LINEFILL: p = PROT_CB_OPCODE;
      IK_NCB: p = PROT_B_OPCODE;
      default: p = PROT_NONCACHED_UNBUFFERED_OPCODE;
    endcase
    p[PROT_PRIV_BIT] = priv;
    return p;
  endfunction

  function automatic logic [3:0] amal_dprot(input amal_dkind_type kind, input logic priv);
    logic [3:0] p;
    case (kind)
      DK_LINEFILL, DK_WTWB: p = PROT_CB_DATA;
      DK_NCB: p = PROT_B_DATA;
      DK_WALK_DATA: p = PROT_WALK_DATA;
      DK_WALK_INSTR: p = PROT_WALK_INSTR;
      DK_WRITEBACK: p = PROT_WRITEBACK;
      default: p = PROT_NONCACHED_UNBUFFERED_DATA;
    endcase
    if (kind != DK_WALK_DATA && kind != DK_WALK_INSTR && kind != DK_WRITEBACK) begin
      p[PROT_PRIV_BIT] = priv;
    end
    return p;
  endfunction

  // Error responses that become aborts on the data master
  function automatic logic amal_abortable(input amal_dkind_type kind, input logic write);
    case (kind)
      DK_WALK_DATA, DK_WALK_INSTR, DK_SWAP: return 1'b1;
      DK_NONCACHED_UNBUFFERED: return 1'b1;
      DK_NCB: return !write;
      default: return 1'b0;
    endcase
  endfunction

endpackage // amal_pkg

// *** core/amal_toggle_sync.sv ***
// Toggle-to-pulse synchroniser for events crossing between clock domains
module amal_toggle_sync (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_toggle,
  output logic o_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= i_toggle;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign o_pulse = sync_reg ^ last_reg;
endmodule // amal_toggle_sync

// *** core/amal_lane_enc.sv ***
// Address alignment and byte lane encoding for one transfer
module amal_lane_enc
  import amal_pkg::*;
(
  input wire logic [1:0] i_addr_low,
  input wire logic [1:0] i_size,
  input wire logic i_big_endian,
  output logic [1:0] o_addr_low,
  output logic [3:0] o_lanes
);
  logic [1:0] lane_idx;

  always_comb begin
    lane_idx = i_big_endian ? ~i_addr_low : i_addr_low;
    if (i_size == SZ_WORD) begin
      o_addr_low = ADDR_LOW_ZERO;
      o_lanes = LANE_ALL;
    end else if (i_size == SZ_HALF) begin
      o_addr_low = {i_addr_low[1], 1'b0};
      o_lanes = (i_addr_low[1] ^ i_big_endian) ? LANE_HIGH_HALF : LANE_LOW_HALF;
    end else begin
      o_addr_low = i_addr_low;
      o_lanes = LANE_B0 << lane_idx;
    end
  end
endmodule // amal_lane_enc

// *** core/amal_top.sv ***
// Two bus masters with protection, lane, lock, clock-enable and abort handling
// Operation
// - Instruction master protection per fetch kind
// - Table walk protection bit 0 shows cause
// - All table walks go on data master
// - Privilege bit follows originating core access, except walks and write-backs (fixed high)
// - Data access protection by region type
// - Linefill and write-back data protection codes
// - Align bus address to access size
// - Every fetch is a word access
// - Data byte lanes from address and endianness
// - Lanes numbered little-endian in both modes
// - Endian output follows control register setting
// - Instruction lock output always low
// - Separate bus clock enable per master
// - Errors abort walks, noncached reads, nonbuffered writes, swaps
// - Errors ignored for cached accesses and buffered writes
// - Handover cycle before first transfer
// - No ordering between the two masters
module amal_top (
  input wire logic i_mclk,
  input wire logic i_hclk,
  input wire logic i_reset_n,
  input wire logic i_big_endian_cfg,
  output logic o_big_endian_indicator,
  input wire logic i_ifetch_req,
  input wire amal_pkg::amal_ikind_type i_ifetch_kind,
  input wire logic i_ifetch_priv,
  input wire logic [31:0] i_ifetch_addr,
  output logic o_ifetch_busy,
  output logic o_ifetch_done,
  output logic [31:0] o_ifetch_rdata,
  input wire logic i_dacc_req,
  input wire amal_pkg::amal_dkind_type i_dacc_kind,
  input wire logic i_dacc_write,
  input wire logic [1:0] i_dacc_size,
  input wire logic i_dacc_priv,
  input wire logic [31:0] i_dacc_addr,
  input wire logic [31:0] i_dacc_wdata,
  output logic o_dacc_busy,
  output logic o_dacc_done,
  output logic o_dacc_abort,
  output logic [31:0] o_dacc_rdata,
  input wire logic i_instr_bus_clock_enable,
  input wire logic i_instr_bus_grant,
  input wire logic i_instr_bus_ready,
  input wire logic [31:0] i_instr_hrdata,
  output logic o_instr_bus_req,
  output logic [1:0] o_instr_htrans,
  output logic [31:0] o_instr_haddr,
  output logic [2:0] o_instr_hsize,
  output logic [3:0] o_instr_master_protection,
  output logic o_instr_master_lock,
  input wire logic i_data_bus_clock_enable,
  input wire logic i_data_bus_grant,
  input wire logic i_data_bus_ready,
  input wire logic i_data_hresp_error,
  input wire logic [31:0] i_data_hrdata,
  output logic o_data_bus_req,
  output logic [1:0] o_data_htrans,
  output logic [31:0] o_data_haddr,
  output logic [2:0] o_data_hsize,
  output logic o_data_hwrite,
  output logic [31:0] o_data_hwdata,
  output logic [3:0] o_data_master_protection,
  output logic [3:0] o_data_byte_lane_strobe,
  output logic o_data_hlock
);
  import amal_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Core side: request capture, endianness, completion
  logic i_tgl_reg, d_tgl_reg;
  amal_ikind_type ik_reg;
  logic ipriv_reg;
  logic [31:0] iaddr_reg;
  amal_dkind_type dk_reg;
  logic dwrite_reg, dpriv_reg, dbe_reg;
  logic [1:0] dsize_reg;
  logic [31:0] daddr_reg, dwdata_reg;
  logic i_done_pulse, d_done_pulse;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_big_endian_indicator <= 1'b0;
    end else begin
      o_big_endian_indicator <= i_big_endian_cfg;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      i_tgl_reg <= 1'b0;
      o_ifetch_busy <= 1'b0;
      ik_reg <= IK_NONCACHED_UNBUFFERED;
      ipriv_reg <= 1'b0;
      iaddr_reg <= 32'h0000_0000;
    end else if (i_ifetch_req && !o_ifetch_busy) begin
      i_tgl_reg <= ~i_tgl_reg;
      o_ifetch_busy <= 1'b1;
      ik_reg <= i_ifetch_kind;
      ipriv_reg <= i_ifetch_priv;
      iaddr_reg <= i_ifetch_addr;
    end else if (i_done_pulse) begin
      o_ifetch_busy <= 1'b0;
    end
  end

  // Endianness is frozen per data access, so a late change cannot alter pending lanes
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      d_tgl_reg <= 1'b0;
      o_dacc_busy <= 1'b0;
      dk_reg <= DK_NONCACHED_UNBUFFERED;
      dwrite_reg <= 1'b0;
      dpriv_reg <= 1'b0;
      dbe_reg <= 1'b0;
      dsize_reg <= SZ_WORD;
      daddr_reg <= 32'h0000_0000;
      dwdata_reg <= 32'h0000_0000;
    end else if (i_dacc_req && !o_dacc_busy) begin
      d_tgl_reg <= ~d_tgl_reg;
      o_dacc_busy <= 1'b1;
      dk_reg <= i_dacc_kind;
      dwrite_reg <= i_dacc_write && i_dacc_kind != DK_SWAP;
      dpriv_reg <= i_dacc_priv;
      dbe_reg <= o_big_endian_indicator;
      dsize_reg <= i_dacc_size;
      daddr_reg <= i_dacc_addr;
      dwdata_reg <= i_dacc_wdata;
    end else if (d_done_pulse) begin
      o_dacc_busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossings
  logic i_start, d_start, i_ack_tgl_reg, d_ack_tgl_reg;

  amal_toggle_sync u_istart (.i_clk(i_hclk), .i_reset_n(i_reset_n), .i_toggle(i_tgl_reg), .o_pulse(i_start));
  amal_toggle_sync u_dstart (.i_clk(i_hclk), .i_reset_n(i_reset_n), .i_toggle(d_tgl_reg), .o_pulse(d_start));
  amal_toggle_sync u_idone (.i_clk(i_mclk), .i_reset_n(i_reset_n), .i_toggle(i_ack_tgl_reg), .o_pulse(i_done_pulse));
  amal_toggle_sync u_ddone (.i_clk(i_mclk), .i_reset_n(i_reset_n), .i_toggle(d_ack_tgl_reg), .o_pulse(d_done_pulse));

  ////////////////////////////////////////////////////////////////////////////
  // Alignment and lanes
  logic [1:0] i_alow, d_alow;
  logic [3:0] d_lanes;

  amal_lane_enc u_ienc (.i_addr_low(iaddr_reg[1:0]), .i_size(SZ_WORD), .i_big_endian(1'b0),
    .o_addr_low(i_alow), .o_lanes());
  amal_lane_enc u_denc (.i_addr_low(daddr_reg[1:0]), .i_size(dsize_reg), .i_big_endian(dbe_reg),
    .o_addr_low(d_alow), .o_lanes(d_lanes));

  ////////////////////////////////////////////////////////////////////////////
  // Instruction master, bus clock domain
  amal_state_type ist_reg;
  logic [31:0] i_rdata_reg;
  logic i_pend_reg, i_go;

  // Start pulse may land on a disabled beat; hold it until taken
  assign i_go = i_start || i_pend_reg;

  always_ff @(posedge i_hclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      i_pend_reg <= 1'b0;
    end else begin
      i_pend_reg <= i_go && !(i_instr_bus_clock_enable && ist_reg == ST_IDLE);
    end
  end

  assign o_instr_master_lock = 1'b0;

  always_ff @(posedge i_hclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ist_reg <= ST_IDLE;
      o_instr_bus_req <= 1'b0;
      o_instr_htrans <= TRANS_IDLE;
      o_instr_haddr <= 32'h0000_0000;
      o_instr_hsize <= 3'h0;
      o_instr_master_protection <= 4'h0;
      i_ack_tgl_reg <= 1'b0;
      i_rdata_reg <= 32'h0000_0000;
    end else if (i_instr_bus_clock_enable) begin
      case (ist_reg)
        ST_IDLE: begin
          if (i_go) begin
            ist_reg <= ST_ARB;
            o_instr_bus_req <= 1'b1;
          end
        end
        ST_ARB: begin
          if (i_instr_bus_grant && i_instr_bus_ready) begin
            ist_reg <= ST_ADDR;
            o_instr_bus_req <= 1'b0;
            o_instr_htrans <= TRANS_NONSEQ;
            o_instr_haddr <= {iaddr_reg[31:2], i_alow};
            o_instr_hsize <= {1'b0, SZ_WORD};
            o_instr_master_protection <= amal_iprot(ik_reg, ipriv_reg);
          end
        end
        ST_ADDR: begin
          if (i_instr_bus_ready) begin
            ist_reg <= ST_DATA;
            o_instr_htrans <= TRANS_IDLE;
          end
        end
        default: begin
          if (i_instr_bus_ready) begin
            ist_reg <= ST_IDLE;
            i_rdata_reg <= i_instr_hrdata;
            i_ack_tgl_reg <= ~i_ack_tgl_reg;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data master, bus clock domain
  amal_state_type dst_reg;
  logic swap_wr_reg, d_abort_reg;
  logic [31:0] d_rdata_reg;
  logic d_pend_reg, d_go;

  // Each master keeps its own pending start, so neither waits on the other
  assign d_go = d_start || d_pend_reg;

  always_ff @(posedge i_hclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      d_pend_reg <= 1'b0;
    end else begin
      d_pend_reg <= d_go && !(i_data_bus_clock_enable && dst_reg == ST_IDLE);
    end
  end

  always_ff @(posedge i_hclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dst_reg <= ST_IDLE;
      swap_wr_reg <= 1'b0;
      o_data_bus_req <= 1'b0;
      o_data_htrans <= TRANS_IDLE;
      o_data_haddr <= 32'h0000_0000;
      o_data_hsize <= 3'h0;
      o_data_hwrite <= 1'b0;
      o_data_hwdata <= 32'h0000_0000;
      o_data_master_protection <= 4'h0;
      o_data_byte_lane_strobe <= 4'h0;
      o_data_hlock <= 1'b0;
      d_abort_reg <= 1'b0;
      d_ack_tgl_reg <= 1'b0;
      d_rdata_reg <= 32'h0000_0000;
    end else if (i_data_bus_clock_enable) begin
      case (dst_reg)
        ST_IDLE: begin
          if (d_go) begin
            dst_reg <= ST_ARB;
            o_data_bus_req <= 1'b1;
            o_data_hlock <= dk_reg == DK_SWAP;
            d_abort_reg <= 1'b0;
            swap_wr_reg <= 1'b0;
          end
        end
        ST_ARB: begin
          if (i_data_bus_grant && i_data_bus_ready) begin
            dst_reg <= ST_ADDR;
            o_data_bus_req <= swap_wr_reg ? 1'b0 : dk_reg == DK_SWAP;
            o_data_htrans <= TRANS_NONSEQ;
            o_data_haddr <= {daddr_reg[31:2], d_alow};
            o_data_hsize <= {1'b0, dsize_reg};
            o_data_hwrite <= dwrite_reg || swap_wr_reg;
            o_data_master_protection <= amal_dprot(dk_reg, dpriv_reg);
            o_data_byte_lane_strobe <= d_lanes;
          end
        end
        ST_ADDR: begin
          if (i_data_bus_ready) begin
            dst_reg <= ST_DATA;
            o_data_htrans <= TRANS_IDLE;
            o_data_hwdata <= dwdata_reg;
          end
        end
        default: begin
          if (i_data_bus_ready) begin
            d_rdata_reg <= o_data_hwrite ? d_rdata_reg : i_data_hrdata;
            if (i_data_hresp_error && amal_abortable(dk_reg, o_data_hwrite)) begin
              d_abort_reg <= 1'b1;
            end
            if (dk_reg == DK_SWAP && !swap_wr_reg) begin
              dst_reg <= ST_ARB;
              swap_wr_reg <= 1'b1;
            end else begin
              dst_reg <= ST_IDLE;
              o_data_hlock <= 1'b0;
              d_ack_tgl_reg <= ~d_ack_tgl_reg;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion back to the core; bus-side values are stable by the pulse
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ifetch_done <= 1'b0;
      o_ifetch_rdata <= 32'h0000_0000;
    end else begin
      o_ifetch_done <= i_done_pulse;
      if (i_done_pulse) begin
        o_ifetch_rdata <= i_rdata_reg;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dacc_done <= 1'b0;
      o_dacc_abort <= 1'b0;
      o_dacc_rdata <= 32'h0000_0000;
    end else begin
      o_dacc_done <= d_done_pulse;
      o_dacc_abort <= d_done_pulse && d_abort_reg;
      if (d_done_pulse) begin
        o_dacc_rdata <= d_rdata_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ilock_low: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    o_instr_htrans == TRANS_NONSEQ |-> !o_instr_master_lock)
    else $error("instruction lock raised");

  a_iprot_fetch: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    o_instr_htrans == TRANS_NONSEQ |-> o_instr_master_protection == amal_iprot(ik_reg, ipriv_reg)
      && !o_instr_master_protection[PROT_DATA_BIT])
    else $error("instruction protection wrong");

  a_ifetch_word: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    o_instr_htrans == TRANS_NONSEQ |-> o_instr_hsize == {1'b0, SZ_WORD} && o_instr_haddr[1:0] == ADDR_LOW_ZERO)
    else $error("fetch not a word access");

  a_walk_cause: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    o_data_htrans == TRANS_NONSEQ && (dk_reg == DK_WALK_DATA || dk_reg == DK_WALK_INSTR)
      |-> o_data_master_protection[3:1] == 3'h7
      && o_data_master_protection[PROT_DATA_BIT] == (dk_reg == DK_WALK_DATA))
    else $error("walk protection wrong");

  a_data_priv: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    o_data_htrans == TRANS_NONSEQ && (dk_reg == DK_NONCACHED_UNBUFFERED || dk_reg == DK_NCB || dk_reg == DK_LINEFILL)
      |-> o_data_master_protection[PROT_PRIV_BIT] == dpriv_reg)
    else $error("privilege bit wrong");

  a_data_region: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    o_data_htrans == TRANS_NONSEQ && dk_reg == DK_NCB |-> o_data_master_protection[3:2] == 2'h1)
    else $error("buffered region protection wrong");

  a_wb_prot: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    o_data_htrans == TRANS_NONSEQ && dk_reg == DK_WRITEBACK |-> o_data_master_protection == PROT_WRITEBACK)
    else $error("write-back protection wrong");

  a_half_align: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    o_data_htrans == TRANS_NONSEQ && o_data_hsize != {1'b0, SZ_BYTE} |-> !o_data_haddr[0]
      && (o_data_hsize != {1'b0, SZ_WORD} || !o_data_haddr[1]))
    else $error("address not aligned");

  a_byte_lane: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    o_data_htrans == TRANS_NONSEQ && o_data_hsize == {1'b0, SZ_BYTE}
      |-> o_data_byte_lane_strobe == (LANE_B0 << (dbe_reg ? ~o_data_haddr[1:0] : o_data_haddr[1:0])))
    else $error("byte lane wrong");

  a_endian_follow: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    ##1 o_big_endian_indicator == $past(i_big_endian_cfg))
    else $error("endian output stale");

  a_hold_no_en: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    !i_data_bus_clock_enable |=> $stable(o_data_htrans) && $stable(o_data_haddr) && $stable(o_data_bus_req))
    else $error("data master moved without enable");

  a_handover_gap: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    dst_reg == ST_IDLE && d_start |=> o_data_htrans == TRANS_IDLE)
    else $error("transfer without arbitration cycle");

  a_error_ignored: assert property (@(posedge i_hclk) disable iff (!i_reset_n)
    dst_reg == ST_DATA && i_data_bus_clock_enable && i_data_bus_ready && (dk_reg == DK_LINEFILL
      || dk_reg == DK_WRITEBACK || dk_reg == DK_WTWB) |=> !d_abort_reg)
    else $error("abort from ignored error");

  c_swap_done: cover property (@(posedge i_hclk) disable iff (!i_reset_n)
    swap_wr_reg && dst_reg == ST_DATA && i_data_bus_ready && i_data_bus_clock_enable);
  c_instr_walk: cover property (@(posedge i_hclk) disable iff (!i_reset_n)
    o_data_htrans == TRANS_NONSEQ && dk_reg == DK_WALK_INSTR);
  c_abort_raised: cover property (@(posedge i_mclk) disable iff (!i_reset_n) o_dacc_abort);
  c_fetch_done: cover property (@(posedge i_mclk) disable iff (!i_reset_n) o_ifetch_done);
endmodule // amal_top

// *** bench/amal_bus_model.sv ***
// Bus-side partner model: arbiter grant, slave ready, error response and read data
module amal_bus_model
  import amal_pkg::*;
(
  input wire logic i_hclk,
  input wire logic i_reset_n,
  input wire logic i_en,
  input wire logic i_req,
  input wire logic [1:0] i_htrans,
  input wire logic [31:0] i_haddr,
  input wire logic i_err_cmd,
  output logic o_grant,
  output logic o_ready,
  output logic o_err,
  output logic [31:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dphase_reg;
  always_ff @(posedge i_hclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_grant <= 1'h0;
      o_ready <= 1'h1;
      o_err <= 1'h0;
      o_rdata <= 32'h0000_0000;
      dphase_reg <= 1'h0;
    end else if (i_en) begin
      // Grant one bus beat after request
      o_grant <= i_req;
      if (i_htrans == TRANS_NONSEQ && o_ready) begin
        dphase_reg <= 1'h1;
        o_rdata <= ~i_haddr;
        o_ready <= ($urandom_range(2) != 0) && !i_err_cmd;
        o_err <= i_err_cmd;
      end else if (dphase_reg && !o_ready) begin
        o_ready <= 1'h1;
      end else if (dphase_reg) begin
        // Released data lines show the inverse
        dphase_reg <= 1'h0;
        o_err <= 1'h0;
        o_rdata <= ~o_rdata;
      end
    end
  end
endmodule // amal_bus_model

// *** bench/amal_top_bench.sv ***
// Self-checking bench for the two bus masters
module amal_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import amal_pkg::*;
  typedef struct packed {
    logic [3:0] prot;
    logic [3:0] lanes;
    logic [31:0] addr;
    logic [2:0] size;
    logic write;
    logic lock;
  } amal_dexp_type;
  logic i_mclk = 0, i_hclk = 0, i_reset_n = 0, i_big_endian_cfg = 0, en = 0, err_cmd = 0;
  logic i_ifetch_req = 0, i_ifetch_priv = 0, i_dacc_req = 0, i_dacc_write = 0, i_dacc_priv = 0;
  amal_ikind_type i_ifetch_kind = IK_NONCACHED_UNBUFFERED;
  amal_dkind_type i_dacc_kind = DK_NONCACHED_UNBUFFERED;
  logic [1:0] i_dacc_size = 0, o_instr_htrans, o_data_htrans;
  logic [31:0] i_ifetch_addr = 0, i_dacc_addr = 0, i_dacc_wdata = 0, i_instr_hrdata, i_data_hrdata;
  logic [31:0] o_ifetch_rdata, o_dacc_rdata, o_instr_haddr, o_data_haddr, o_data_hwdata;
  logic o_big_endian_indicator, o_ifetch_busy, o_ifetch_done, o_dacc_busy, o_dacc_done, o_dacc_abort;
  logic i_instr_bus_grant, i_instr_bus_ready, i_data_bus_grant, i_data_bus_ready, i_data_hresp_error;
  logic o_instr_bus_req, o_instr_master_lock, o_data_bus_req, o_data_hwrite, o_data_hlock;
  logic [2:0] o_instr_hsize, o_data_hsize;
  logic [3:0] o_instr_master_protection, o_data_master_protection, o_data_byte_lane_strobe;
  wire i_instr_bus_clock_enable = en;
  wire i_data_bus_clock_enable = en;
  int n_errors = 0, n_compared = 0;
  amal_dexp_type q_dbus[$];
  logic [35:0] q_ibus[$];
  logic [33:0] q_ddone[$];
  logic [31:0] q_idone[$];
  amal_dexp_type dx;
  logic [35:0] ix;
  logic [33:0] dd;

  amal_top u_dut (.i_mclk, .i_hclk, .i_reset_n, .i_big_endian_cfg, .o_big_endian_indicator, .i_ifetch_req,
    .i_ifetch_kind, .i_ifetch_priv, .i_ifetch_addr, .o_ifetch_busy, .o_ifetch_done, .o_ifetch_rdata, .i_dacc_req,
    .i_dacc_kind, .i_dacc_write, .i_dacc_size, .i_dacc_priv, .i_dacc_addr, .i_dacc_wdata, .o_dacc_busy,
    .o_dacc_done, .o_dacc_abort, .o_dacc_rdata, .i_instr_bus_clock_enable, .i_instr_bus_grant, .i_instr_bus_ready,
    .i_instr_hrdata, .o_instr_bus_req, .o_instr_htrans, .o_instr_haddr, .o_instr_hsize, .o_instr_master_protection,
    .o_instr_master_lock, .i_data_bus_clock_enable, .i_data_bus_grant, .i_data_bus_ready, .i_data_hresp_error,
    .i_data_hrdata, .o_data_bus_req, .o_data_htrans, .o_data_haddr, .o_data_hsize, .o_data_hwrite, .o_data_hwdata,
    .o_data_master_protection, .o_data_byte_lane_strobe, .o_data_hlock);
  amal_bus_model u_ibus (.i_hclk, .i_reset_n, .i_en(en), .i_req(o_instr_bus_req), .i_htrans(o_instr_htrans),
    .i_haddr(o_instr_haddr), .i_err_cmd(1'h0), .o_grant(i_instr_bus_grant), .o_ready(i_instr_bus_ready),
    .o_err(), .o_rdata(i_instr_hrdata));
  amal_bus_model u_dbus (.i_hclk, .i_reset_n, .i_en(en), .i_req(o_data_bus_req), .i_htrans(o_data_htrans),
    .i_haddr(o_data_haddr), .i_err_cmd(err_cmd), .o_grant(i_data_bus_grant), .o_ready(i_data_bus_ready),
    .o_err(i_data_hresp_error), .o_rdata(i_data_hrdata));

  initial begin
    forever #25 i_mclk = ~i_mclk;
  end
  initial begin
    #7;
    forever #80 i_hclk = ~i_hclk;
  end
  always @(posedge i_hclk) en <= $urandom_range(3) != 0;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_done(input bit d);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(negedge i_mclk);
      if ((d ? o_dacc_done : o_ifetch_done) === 1'h1) break;
    end
    if (n == 3000) begin
      n_errors++;
      complete_run();
    end
  endtask
  function automatic logic [3:0] exp_prot(input amal_dkind_type k, input logic p);
    case (k)
      DK_LINEFILL, DK_WTWB: return {2'h3, p, 1'h1};
      DK_NCB: return {2'h1, p, 1'h1};
      DK_WALK_DATA, DK_WRITEBACK: return 4'hf;
      DK_WALK_INSTR: return 4'he;
      default: return {2'h0, p, 1'h1};
    endcase
  endfunction
  function automatic logic [3:0] exp_lanes(input logic [1:0] sz, input logic [1:0] a, input logic b);
    if (sz == SZ_BYTE) return 4'h1 << (b ? 2'h3 - a : a);
    if (sz == SZ_HALF) return (a[1] ^ b) ? 4'hc : 4'h3;
    return 4'hf;
  endfunction
  task automatic do_data(input amal_dkind_type k, input logic w, input logic [1:0] sz, input logic p,
      input logic [31:0] a, input logic e);
    logic wr;
    logic [1:0] lo;
    logic [31:0] wd;
    amal_dexp_type x;
    wr = (k == DK_SWAP) ? 1'h0 : w;
    wd = $urandom;
    lo = (sz == SZ_WORD) ? 2'h0 : (sz == SZ_HALF) ? {a[1], 1'h0} : a[1:0];
    x = '{exp_prot(k, p), exp_lanes(sz, a[1:0], i_big_endian_cfg), {a[31:2], lo}, {1'h0, sz}, wr, k == DK_SWAP};
    q_dbus.push_back(x);
    if (k == DK_SWAP) begin
      x.write = 1'h1;
      q_dbus.push_back(x);
    end
    q_ddone.push_back({!wr, e && (k inside {DK_WALK_DATA, DK_WALK_INSTR, DK_NONCACHED_UNBUFFERED, DK_SWAP} || (k == DK_NCB && !wr)),
      wr ? wd : ~x.addr});
    @(posedge i_mclk);
    i_dacc_req <= 1'h1;
    i_dacc_kind <= k;
    {i_dacc_write, i_dacc_size, i_dacc_priv, i_dacc_addr} <= {w, sz, p, a};
    i_dacc_wdata <= wd;
    err_cmd <= e;
    @(posedge i_mclk);
    i_dacc_req <= 1'h0;
    wait_done(1);
  endtask
  task automatic do_fetch(input amal_ikind_type k, input logic p, input logic [31:0] a);
    logic [3:0] pr;
    pr = (k == IK_LINEFILL) ? {2'h3, p, 1'h0} : (k == IK_NCB) ? {2'h1, p, 1'h0} : {2'h0, p, 1'h0};
    q_ibus.push_back({pr, a[31:2], 2'h0});
    q_idone.push_back(~{a[31:2], 2'h0});
    @(posedge i_mclk);
    i_ifetch_kind <= k;
    {i_ifetch_req, i_ifetch_priv, i_ifetch_addr} <= {1'h1, p, a};
    @(posedge i_mclk);
    i_ifetch_req <= 1'h0;
    wait_done(0);
  endtask

  always @(posedge i_hclk) begin
    if (en === 1'h1 && i_data_bus_ready === 1'h1 && o_data_htrans === TRANS_NONSEQ) begin
      dx = q_dbus.pop_front();
      check("dprot", o_data_master_protection, dx.prot);
      check("lanes", o_data_byte_lane_strobe, dx.lanes);
      check("daddr", o_data_haddr, dx.addr);
      check("dsize", o_data_hsize, dx.size);
      check("hwrite", o_data_hwrite, dx.write);
      check("hlock", o_data_hlock, dx.lock);
    end
    if (en === 1'h1 && i_instr_bus_ready === 1'h1 && o_instr_htrans === TRANS_NONSEQ) begin
      ix = q_ibus.pop_front();
      check("iprot", o_instr_master_protection, ix[35:32]);
      check("iaddr", o_instr_haddr, ix[31:0]);
      check("isize", o_instr_hsize, 3'h2);
      check("ilock", o_instr_master_lock, 1'h0);
    end
  end
  always @(negedge i_mclk) begin
    if (o_dacc_done === 1'h1) begin
      dd = q_ddone.pop_front();
      check("abort", o_dacc_abort, dd[32]);
      if (dd[33]) check("drdata", o_dacc_rdata, dd[31:0]);
      if (!dd[33]) check("hwdata", o_data_hwdata, dd[31:0]);
    end
    if (o_ifetch_done === 1'h1) check("irdata", o_ifetch_rdata, q_idone.pop_front());
  end

  initial begin
    amal_dkind_type k;
    logic w;
    logic [1:0] sz;
    void'($urandom(47));
    repeat (4) @(posedge i_mclk);
    i_reset_n <= 1'h1;
    for (int i = 0; i < 48; i++) begin
      if (i % 16 == 0) begin
        @(posedge i_mclk);
        i_big_endian_cfg <= i[4];
        repeat (3) @(posedge i_mclk);
        check("endian", o_big_endian_indicator, i[4]);
      end
      k = amal_dkind_type'(i % 8);
      sz = (k inside {DK_NONCACHED_UNBUFFERED, DK_NCB, DK_SWAP, DK_WTWB}) ? 2'($urandom_range(2)) : SZ_WORD;
      w = (k inside {DK_NONCACHED_UNBUFFERED, DK_NCB}) ? 1'($urandom_range(1)) : (k inside {DK_WTWB, DK_WRITEBACK});
      // Both masters at once, in no fixed order
      fork
        do_fetch(amal_ikind_type'(i % 3), i[3], $urandom);
        do_data(k, w, sz, 1'($urandom_range(1)), $urandom, 1'($urandom_range(1)));
      join
    end
    complete_run();
  end
endmodule // amal_top_bench
